//--- design/tim_pkg.sv
package tim_pkg;
    // register addresses on the serial interface
    localparam logic [5:0] MASK_ADDR = 6'h05;
    localparam logic [5:0] STATUS_ADDR = 6'h24;
    // mask register field positions
    localparam int ATTN_EN_POS = 15;
    localparam int RAM_ADDR_EN_POS = 12;
    localparam int ARB_BUSY_EN_POS = 11;
    localparam int STRM_DATA_EN_POS = 10;
    localparam int LO_UNLOCK_EN_POS = 9;
    localparam int DEEP_SLEEP_POS = 8;
    localparam int SLEEP_TMR_EN_POS = 4;
    localparam int CMP4_EN_POS = 3;
    localparam int CMP3_EN_POS = 2;
    localparam int CMP2_EN_POS = 1;
    localparam int CMP1_EN_POS = 0;
    // writable bits of the mask register; reserved bits 14:13 and 7:5 are held
    localparam logic [15:0] MASK_WR_BITS = 16'h9f1f;
    localparam logic [15:0] MASK_RESET = 16'h8000;
    // status register layout (same positions as the enables)
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_SRC_BITS = 16'h9e1f;
    // serial frame: 1 rw bit, 1 spare, 6 address bits, 16 data bits
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] HDR_LAST = 5'd7;
    localparam logic [4:0] FRAME_LAST = 5'd23;
    typedef enum logic [1:0] {
        TIM_AWAKE = 2'b00,
        TIM_ASLEEP = 2'b01
    } tim_sleep_t;
endpackage

//--- design/tim_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin inputs
module tim_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,           // system clock
    input wire logic rstn_i,              // sync reset, active low
    input wire logic [WIDTH-1:0] async_i, // raw pin levels
    output logic [WIDTH-1:0] sync_o       // synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule // tim_sync
`default_nettype wire

//--- design/tim_irq_mask.sv
`timescale 1ns/1ps
`default_nettype none
module tim_irq_mask (
    input wire logic clk_sys_i,           // system clock, 200 MHz
    input wire logic rstn_i,              // sync reset, active low
    input wire logic spi_cs_n_i,          // serial chip enable, active low
    input wire logic spi_sck_i,           // serial clock pin, sampled
    input wire logic spi_mosi_i,          // serial data in
    output logic spi_miso_o,              // serial data out
    output logic spi_miso_oe_o,           // data out enable, high when driving
    input wire logic attn_n_i,            // attention pin, active low
    input wire logic [15:0] src_event_i,  // one-cycle source events, status layout
    input wire logic sleep_req_i,         // core asks to enter sleep
    output logic irq_n_o,                 // interrupt request, active low
    output logic asleep_o,                // device in sleep state
    output logic tmr_clk_en_o             // event timer and prescaler clock enable
);
    logic [1:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic mosi_s;
    logic attn_n_s;
    logic sck_d_ff;
    logic [4:0] bit_cnt_ff;
    logic [7:0] hdr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] shift_ff;
    logic miso_ff;
    logic miso_oe_ff;
    logic [15:0] mask_ff;
    logic [15:0] status_ff;
    logic irq_n_ff;
    tim_pkg::tim_sleep_t sleep_ff;
    logic tmr_clk_en_ff;
    logic sck_rise;
    logic sck_fall;
    logic is_read;
    logic [5:0] hdr_addr;
    logic hdr_done;
    logic status_rd;
    logic mask_wr;
    logic [15:0] nxt_status;
    logic [15:0] nxt_mask;
    logic wake_attn;
    logic wake_tc2;
    tim_pkg::tim_sleep_t nxt_sleep;
    logic asleep_ff;

    // serial clock and data cross into the system clock; both idle low
    tim_sync #(.WIDTH(2)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .async_i({spi_sck_i, spi_mosi_i}),
        .sync_o(pins_s)
    );
    logic cs_meta_ff;
    logic cs_sync_ff;
    logic attn_meta_ff;
    logic attn_sync_ff;
    // chip enable and attention idle high; a low reset value would fake a wake-up
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            attn_meta_ff <= 1'b1;
            attn_sync_ff <= 1'b1;
        end else begin
            cs_meta_ff <= spi_cs_n_i;
            cs_sync_ff <= cs_meta_ff;
            attn_meta_ff <= attn_n_i;
            attn_sync_ff <= attn_meta_ff;
        end
    end
    assign cs_n_s = cs_sync_ff;
    assign sck_s = pins_s[1];
    assign mosi_s = pins_s[0];
    assign attn_n_s = attn_sync_ff;

    // edge detect on the synchronised clock
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            sck_d_ff <= 1'b0;
        end else begin
            sck_d_ff <= sck_s;
        end
    end
    assign sck_rise = !cs_n_s && sck_s && !sck_d_ff;
    assign sck_fall = !cs_n_s && !sck_s && sck_d_ff;

    // header: bit 7 is read flag, bits 5:0 address
    assign is_read = hdr_ff[7];
    assign hdr_addr = hdr_ff[5:0];
    assign hdr_done = bit_cnt_ff > tim_pkg::HDR_LAST;

    // serial shift engine, mode 0, msb first
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || cs_n_s) begin
            bit_cnt_ff <= '0;
            hdr_ff <= '0;
            wdata_ff <= '0;
        end else if (sck_rise && bit_cnt_ff <= tim_pkg::FRAME_LAST) begin
            bit_cnt_ff <= bit_cnt_ff + 5'd1;
            if (!hdr_done) begin
                hdr_ff <= {hdr_ff[6:0], mosi_s};
            end else begin
                wdata_ff <= {wdata_ff[14:0], mosi_s};
            end
        end
    end

    // address as it stands while the last header bit is on the data line
    function automatic logic [5:0] last_hdr_addr(input logic [4:0] upper, input logic low);
        return {upper, low};
    endfunction

    // read data: loaded once the header is in, shifted on falling edges
    // status is snapshotted here so the clear below never loses the shown value
    // the fall right after the header is skipped, so bit 15 stands until the next rise
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || cs_n_s) begin
            shift_ff <= '0;
        end else if (status_rd) begin
            shift_ff <= status_ff;
        end else if (sck_rise && bit_cnt_ff == tim_pkg::HDR_LAST && hdr_ff[6]
                     && last_hdr_addr(hdr_ff[4:0], mosi_s) == tim_pkg::MASK_ADDR) begin
            shift_ff <= mask_ff;
        end else if (sck_fall && bit_cnt_ff > tim_pkg::HDR_LAST + 5'd1) begin
            shift_ff <= {shift_ff[14:0], 1'b0};
        end
    end

    // a status read is taken at the last header bit
    assign status_rd = sck_rise && bit_cnt_ff == tim_pkg::HDR_LAST && hdr_ff[6]
                       && last_hdr_addr(hdr_ff[4:0], mosi_s) == tim_pkg::STATUS_ADDR;

    // write commits on the final data bit
    assign mask_wr = sck_rise && bit_cnt_ff == tim_pkg::FRAME_LAST && !is_read
                     && hdr_addr == tim_pkg::MASK_ADDR;

    // pin output registered, driven only in the data phase of a read
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            miso_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else begin
            miso_ff <= shift_ff[15];
            miso_oe_ff <= !cs_n_s && hdr_done && is_read;
        end
    end

    // mask register; reserved positions never change
    always_comb begin
        nxt_mask = mask_ff;
        if (mask_wr) begin
            nxt_mask = ({wdata_ff[14:0], mosi_s} & tim_pkg::MASK_WR_BITS)
                       | (mask_ff & ~tim_pkg::MASK_WR_BITS);
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            mask_ff <= tim_pkg::MASK_RESET;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // status latch: new events win over the read clear
    always_comb begin
        nxt_status = status_ff;
        if (status_rd) begin
            nxt_status = '0;
        end
        nxt_status = nxt_status | (src_event_i & tim_pkg::STATUS_SRC_BITS);
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            status_ff <= tim_pkg::STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // request output from next-state, so it changes in the same cycle as status and mask
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= !(|(nxt_status & nxt_mask & tim_pkg::STATUS_SRC_BITS));
        end
    end

    // sleep control: deep mode ignores comparator two
    assign wake_attn = !attn_n_s;
    assign wake_tc2 = src_event_i[tim_pkg::CMP2_EN_POS] && !mask_ff[tim_pkg::DEEP_SLEEP_POS];
    always_comb begin
        nxt_sleep = sleep_ff;
        unique case (sleep_ff)
            tim_pkg::TIM_AWAKE: begin
                if (sleep_req_i && !wake_attn) begin
                    nxt_sleep = tim_pkg::TIM_ASLEEP;
                end
            end
            tim_pkg::TIM_ASLEEP: begin
                if (wake_attn || wake_tc2) begin
                    nxt_sleep = tim_pkg::TIM_AWAKE;
                end
            end
            default: nxt_sleep = tim_pkg::TIM_AWAKE;
        endcase
    end

    // sleep state register
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            sleep_ff <= tim_pkg::TIM_AWAKE;
        end else begin
            sleep_ff <= nxt_sleep;
        end
    end

    // pin copy of the state, so the output leaves a flop and not a compare
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            asleep_ff <= 1'b0;
        end else begin
            asleep_ff <= nxt_sleep == tim_pkg::TIM_ASLEEP;
        end
    end

    // timer clocks stop one cycle behind the sleep state, and only in deep mode
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            tmr_clk_en_ff <= 1'b1;
        end else begin
            tmr_clk_en_ff <= !(sleep_ff == tim_pkg::TIM_ASLEEP
                               && mask_ff[tim_pkg::DEEP_SLEEP_POS]);
        end
    end

    assign spi_miso_o = miso_ff;
    assign spi_miso_oe_o = miso_oe_ff;
    assign irq_n_o = irq_n_ff;
    assign asleep_o = asleep_ff;
    assign tmr_clk_en_o = tmr_clk_en_ff;

    // assertions
    irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        |(status_ff & mask_ff & tim_pkg::STATUS_SRC_BITS) |-> !irq_n_o)
        else $error("enabled status without request");
    irq_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !(|(status_ff & mask_ff)) |-> irq_n_o)
        else $error("request without enabled status");
    rd_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        status_rd && !(|src_event_i) |=> status_ff == 16'h0000)
        else $error("status not cleared by read");
    rsv_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (mask_ff & ~tim_pkg::MASK_WR_BITS) == 16'h0000)
        else $error("reserved mask bits changed");
    attn_reset_a: assert property (@(posedge clk_sys_i)
        !rstn_i |=> mask_ff[tim_pkg::ATTN_EN_POS])
        else $error("attention enable not set after reset");
    deep_wake_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        asleep_o && mask_ff[tim_pkg::DEEP_SLEEP_POS] && attn_n_s |=> asleep_o)
        else $error("deep sleep left without attention");
    tc2_wake_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        asleep_o && !mask_ff[tim_pkg::DEEP_SLEEP_POS] && src_event_i[tim_pkg::CMP2_EN_POS]
        |=> !asleep_o)
        else $error("comparator two did not wake");
    clk_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        asleep_o && mask_ff[tim_pkg::DEEP_SLEEP_POS]
        |=> !tmr_clk_en_o || !asleep_o || !mask_ff[tim_pkg::DEEP_SLEEP_POS])
        else $error("timer clocks run in deep sleep");
    // outputs idle straight after any reset edge
    rst_idle_a: assert property (@(posedge clk_sys_i)
        !rstn_i |=> irq_n_o && tmr_clk_en_o && !asleep_o && !spi_miso_oe_o)
        else $error("outputs not idle after reset");

    // a status read with no new events, then the request released with status empty
    sequence quiet_read_s;
        status_rd && !(|src_event_i) ##1 !(|src_event_i);
    endsequence
    sequence irq_released_s;
        irq_n_o && status_ff == tim_pkg::STATUS_RESET;
    endsequence
    rd_release_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        quiet_read_s |=> irq_released_s)
        else $error("request held after status read");

    // sleep entry needs attention idle; attention always ends sleep
    sequence sleep_ask_s;
        !asleep_o && sleep_req_i && attn_n_s;
    endsequence
    sleep_enter_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        sleep_ask_s |=> asleep_o)
        else $error("sleep request not taken");
    attn_wake_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        asleep_o && !attn_n_s |=> !asleep_o)
        else $error("attention did not wake");
    clk_run_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !asleep_o |=> tmr_clk_en_o)
        else $error("timer clocks stopped while awake");
endmodule // tim_irq_mask
`default_nettype wire

//--- verif/tim_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host controller acting as serial master; sck stands still between frames
module tim_host_model (
    input wire logic clk_sys_i, // system clock
    input wire logic miso_i,    // serial data from the device
    output logic cs_n_o,        // chip enable, active low
    output logic sck_o,         // serial clock, idle low
    output logic mosi_o         // serial data to the device
);
    localparam int HALF = 6; // sck phase in clk cycles, above the sync minimum of 4
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // one 24-bit frame msb first; read data sampled just before each data rise
    task automatic frame(input logic rd, input logic [5:0] addr, input logic [15:0] wd,
                         output logic [15:0] rdat);
        logic [23:0] word;
        word = {rd, 1'b0, addr, wd};
        rdat = 16'h0000;
        @(negedge clk_sys_i);
        cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            mosi_o = word[i];
            repeat (HALF) @(negedge clk_sys_i);
            if (i < 16) rdat = {rdat[14:0], miso_i};
            sck_o = 1'b1;
            repeat (HALF) @(negedge clk_sys_i);
            sck_o = 1'b0;
        end
        mosi_o = ~word[0]; // released line must not keep showing the last bit
        repeat (HALF) @(negedge clk_sys_i);
        cs_n_o = 1'b1;
        repeat (HALF) @(negedge clk_sys_i);
    endtask
endmodule // tim_host_model
`default_nettype wire

//--- verif/transceiver_irq_mask_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module transceiver_irq_mask_unit_bench;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic attn_n_i = 1'b1;
    logic [15:0] src_event_i = 16'h0000;
    logic sleep_req_i = 1'b0;
    logic cs_n, sck, mosi, miso, miso_oe, irq_n, asleep, tmr_clk_en;
    wire logic miso_w;
    int num_errors = 0;
    int total_checks = 0;
    logic [15:0] rd;
    int src_pos [10] = '{15, 12, 11, 10, 9, 4, 3, 2, 1, 0};
    // undriven data line reads as pulled up
    assign miso_w = miso_oe ? miso : 1'b1;
    always #2.5 clk_sys_i = ~clk_sys_i;
    tim_irq_mask u_dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .attn_n_i(attn_n_i), .src_event_i(src_event_i), .sleep_req_i(sleep_req_i),
        .irq_n_o(irq_n), .asleep_o(asleep), .tmr_clk_en_o(tmr_clk_en)
    );
    tim_host_model u_host (
        .clk_sys_i(clk_sys_i), .miso_i(miso_w), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi)
    );
    // compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        u_host.frame(1'b0, a, d, rd);
    endtask
    task automatic rdchk(input string nm, input logic [5:0] a, input logic [15:0] exp);
        u_host.frame(1'b1, a, 16'h0000, rd);
        chk(nm, exp, rd);
    endtask
    // drive one cycle on an input, then let the syncs settle
    task automatic pulse(input logic [15:0] ev, input logic slp);
        @(negedge clk_sys_i);
        src_event_i = ev;
        sleep_req_i = slp;
        @(negedge clk_sys_i);
        src_event_i = 16'h0000;
        sleep_req_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
    endtask
    task automatic test_reset();
        chk("irq_n_o", 16'h0001, {15'h0000, irq_n});
        chk("tmr_clk_en_o", 16'h0001, {15'h0000, tmr_clk_en});
        rdchk("mask", tim_pkg::MASK_ADDR, 16'h8000);
        rdchk("status", tim_pkg::STATUS_ADDR, 16'h0000);
        pulse(16'h8000, 1'b0);
        chk("irq_n_o attn", 16'h0000, {15'h0000, irq_n});
    endtask
    // each source: set while masked, then enable, then clear by reading
    task automatic test_sources();
        logic [15:0] b;
        for (int k = 0; k < 10; k++) begin
            b = 16'h0001 << src_pos[k];
            wr(tim_pkg::MASK_ADDR, 16'h0000);
            pulse(b, 1'b0);
            chk("irq_n_o masked", 16'h0001, {15'h0000, irq_n});
            wr(tim_pkg::MASK_ADDR, b);
            chk("irq_n_o enabled", 16'h0000, {15'h0000, irq_n});
            rdchk("status", tim_pkg::STATUS_ADDR, b);
            repeat (2) @(negedge clk_sys_i);
            chk("irq_n_o cleared", 16'h0001, {15'h0000, irq_n});
        end
    endtask
    task automatic test_reserved();
        wr(tim_pkg::MASK_ADDR, 16'hffff);
        rdchk("mask reserved", tim_pkg::MASK_ADDR, 16'h9f1f);
        wr(6'h06, 16'h0000);
        rdchk("mask after other write", tim_pkg::MASK_ADDR, 16'h9f1f);
        rdchk("unmapped read", 6'h06, 16'h0000);
    endtask
    task automatic test_sleep();
        wr(tim_pkg::MASK_ADDR, 16'h0100);
        pulse(16'h0000, 1'b1);
        chk("asleep deep", 16'h0001, {15'h0000, asleep});
        chk("tmr_clk_en deep", 16'h0000, {15'h0000, tmr_clk_en});
        pulse(16'h0002, 1'b0);
        chk("asleep after match", 16'h0001, {15'h0000, asleep});
        attn_n_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        attn_n_i = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        chk("asleep after attn", 16'h0000, {15'h0000, asleep});
        chk("tmr_clk_en woken", 16'h0001, {15'h0000, tmr_clk_en});
        wr(tim_pkg::MASK_ADDR, 16'h0000);
        pulse(16'h0000, 1'b1);
        chk("asleep normal", 16'h0001, {15'h0000, asleep});
        pulse(16'h0002, 1'b0);
        chk("asleep woken", 16'h0000, {15'h0000, asleep});
        u_host.frame(1'b1, tim_pkg::STATUS_ADDR, 16'h0000, rd);
    endtask
    // reset in mid-run with the mask cleared and a status pending
    task automatic test_rerun();
        wr(tim_pkg::MASK_ADDR, 16'h0000);
        pulse(16'h8000, 1'b0);
        rstn_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk("irq_n_o rerun", 16'h0001, {15'h0000, irq_n});
        rdchk("mask rerun", tim_pkg::MASK_ADDR, 16'h8000);
        rdchk("status rerun", tim_pkg::STATUS_ADDR, 16'h0000);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog: about three times the expected run of some forty frames
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (6) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        test_reset();
        test_sources();
        test_reserved();
        test_sleep();
        test_rerun();
        conclude();
    end
endmodule // transceiver_irq_mask_unit_bench
`default_nettype wire
